// ---- include/bst_tap_regs.vh ----
`ifndef BST_TAP_REGS_VH
`define BST_TAP_REGS_VH
`define BST_IR_WIDTH 3
`define BST_IR_CAPTURE 3'h1
`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE 3'h1
`define BST_OP_SAMPLEZ 3'h2
`define BST_OP_SAMPLE 3'h4
`define BST_OP_BYPASS 3'h7
`define BST_BSR_LEN 109
`define BST_OE_CELL 108
`define BST_ID_WIDTH 32
`define BST_OFF_CTRL 32'h00000000
`define BST_OFF_STATUS 32'h00000004
`define BST_OFF_IDCODE 32'h00000008
`define BST_CTRL_RESET 32'h00000000
`define BST_AXI_OKAY 2'h0
`define BST_AXI_SLVERR 2'h2
`endif

// ---- hdl/bst_tap.v ----
// Overview of operation
// - exactly one data register sits between tdi and tdo, picked by instruction.
// - tdi sampled at tck rise; tdo changes at tck fall.
// - three-bit instruction register shifts during Shift-IR.
// - instruction forced to identification at power-up and in reset state.
// - Capture-IR loads low two instruction bits with 01.
// - bypass register is one bit, cleared under bypass instruction.
// - boundary register captures pin ring in Capture-DR, shifts in Shift-DR.
// - every scan register takes tdi at msb and drives tdo from lsb.
// - identification register captures fixed 32-bit code and shifts it out.
// - new instruction takes effect only at Update-IR.
// - high-impedance sample selects boundary register, tristates output bus.
// - sample/preload snapshots all pins in Capture-DR.
// - preload places shifted pattern on latched parallel cell outputs.
// - sample data shifts out while preload data shifts in.
// - bypass instruction routes tdi to tdo through one bypass bit.
// - external test drives preloaded values onto output pins.
// - cell 108 latched at Update-DR gates output bus under external test.
// - output-enable cell preset to one at power-up and in reset state.
// - state transitions follow tms sampled at each tck rise.
// - five tck rises with tms high reset the controller.
// - codes 000 external test, 001 identification, 010 high-impedance sample.
// - 100 sample/preload, 111 bypass; 011, 101, 110 reserved.
`include "bst_tap_regs.vh"
module bst_tap #(
  parameter [31:0] ID_CODE = 32'h0ABCD001
) (
  input wire sys_clk,
  input wire reset_n,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdoOe_n,
  input wire [107:0] pinRing,
  output wire [107:0] cellOut,
  output wire extestDrive,
  output wire outBusEnable,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [3:0] ST_RESET = 4'h0;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SHF_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PAU_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'hA;
  localparam [3:0] ST_SHF_IR = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC;
  localparam [3:0] ST_PAU_IR = 4'hD;
  localparam [3:0] ST_EX2_IR = 4'hE;
  localparam [3:0] ST_UPD_IR = 4'hF;

  reg rstMeta_q, rstSync_q;
  wire rstN;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  assign rstN = rstSync_q;

  // two-flop sync of all tap pins; edges found on the synced clock only
  reg [2:0] pinMeta_q, pinSync_q;
  reg tckLast_q;
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta_q <= 3'h3;
      pinSync_q <= 3'h3;
      tckLast_q <= 1'b0;
    end else begin
      pinMeta_q <= {tck, tms, tdi};
      pinSync_q <= pinMeta_q;
      tckLast_q <= pinSync_q[2];
    end
  end
  wire tckRise = pinSync_q[2] & ~tckLast_q;
  wire tckFall = ~pinSync_q[2] & tckLast_q;
  wire tmsS = pinSync_q[1];
  wire tdiS = pinSync_q[0];

  reg [3:0] state_q, state_d;
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (tmsS) state_d = ST_RESET;
        else state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (tmsS) state_d = ST_SEL_DR;
        else state_d = ST_IDLE;
      end
      ST_SEL_DR: begin
        if (tmsS) state_d = ST_SEL_IR;
        else state_d = ST_CAP_DR;
      end
      ST_CAP_DR: begin
        if (tmsS) state_d = ST_EX1_DR;
        else state_d = ST_SHF_DR;
      end
      ST_SHF_DR: begin
        if (tmsS) state_d = ST_EX1_DR;
        else state_d = ST_SHF_DR;
      end
      ST_EX1_DR: begin
        if (tmsS) state_d = ST_UPD_DR;
        else state_d = ST_PAU_DR;
      end
      ST_PAU_DR: begin
        if (tmsS) state_d = ST_EX2_DR;
        else state_d = ST_PAU_DR;
      end
      ST_EX2_DR: begin
        if (tmsS) state_d = ST_UPD_DR;
        else state_d = ST_SHF_DR;
      end
      ST_UPD_DR: begin
        if (tmsS) state_d = ST_SEL_DR;
        else state_d = ST_IDLE;
      end
      ST_SEL_IR: begin
        if (tmsS) state_d = ST_RESET;
        else state_d = ST_CAP_IR;
      end
      ST_CAP_IR: begin
        if (tmsS) state_d = ST_EX1_IR;
        else state_d = ST_SHF_IR;
      end
      ST_SHF_IR: begin
        if (tmsS) state_d = ST_EX1_IR;
        else state_d = ST_SHF_IR;
      end
      ST_EX1_IR: begin
        if (tmsS) state_d = ST_UPD_IR;
        else state_d = ST_PAU_IR;
      end
      ST_PAU_IR: begin
        if (tmsS) state_d = ST_EX2_IR;
        else state_d = ST_PAU_IR;
      end
      ST_EX2_IR: begin
        if (tmsS) state_d = ST_UPD_IR;
        else state_d = ST_SHF_IR;
      end
      ST_UPD_IR: begin
        if (tmsS) state_d = ST_SEL_DR;
        else state_d = ST_IDLE;
      end
      default: state_d = ST_RESET;
    endcase
  end

  reg [2:0] irShift_q, irCur_q;
  reg bypass_q;
  reg [31:0] idShift_q;
  reg [108:0] bsrShift_q, bsrUpd_q;
  reg [2:0] tmsCount_q;

  // reserved codes fall through to bypass so the chain stays one register
  wire selBsr = (irCur_q == `BST_OP_EXTEST) | (irCur_q == `BST_OP_SAMPLEZ) |
                (irCur_q == `BST_OP_SAMPLE);
  wire selId = (irCur_q == `BST_OP_IDCODE);

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= ST_RESET;
      irShift_q <= `BST_OP_IDCODE;
      irCur_q <= `BST_OP_IDCODE;
      bypass_q <= 1'b0;
      idShift_q <= 32'h00000000;
      bsrShift_q <= {`BST_BSR_LEN{1'b0}};
      bsrUpd_q <= {1'b1, 108'h0};
      tmsCount_q <= 3'h0;
    end else if (tckRise) begin
      state_q <= state_d;
      if (!tmsS) begin
        tmsCount_q <= 3'h0;
      end else if (tmsCount_q != 3'h5) begin
        tmsCount_q <= tmsCount_q + 3'h1;
      end
      case (state_q)
        ST_RESET: begin
          irCur_q <= `BST_OP_IDCODE;
          bsrUpd_q[`BST_OE_CELL] <= 1'b1;
        end
        ST_CAP_IR: begin
          irShift_q <= (irCur_q & 3'h4) | `BST_IR_CAPTURE;
        end
        ST_SHF_IR: begin
          irShift_q <= {tdiS, irShift_q[2:1]};
        end
        ST_UPD_IR: begin
          irCur_q <= irShift_q;
        end
        ST_CAP_DR: begin
          if (selBsr) begin
            bsrShift_q <= {bsrUpd_q[`BST_OE_CELL], pinRing};
          end else if (selId) begin
            idShift_q <= ID_CODE;
          end else begin
            bypass_q <= 1'b0;
          end
        end
        ST_SHF_DR: begin
          // sample out and preload in share one pass
          if (selBsr) begin
            bsrShift_q <= {tdiS, bsrShift_q[108:1]};
          end else if (selId) begin
            idShift_q <= {tdiS, idShift_q[31:1]};
          end else begin
            bypass_q <= tdiS;
          end
        end
        ST_UPD_DR: begin
          if (selBsr) bsrUpd_q <= bsrShift_q;
        end
        default: ;
      endcase
      // presets land on entry, so the output bus is released without waiting a tck
      if (state_d == ST_RESET) begin
        irCur_q <= `BST_OP_IDCODE;
        bsrUpd_q[`BST_OE_CELL] <= 1'b1;
      end
    end
  end

  // tdo updated only at the falling tck edge
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      tdo <= 1'b0;
      tdoOe_n <= 1'b1;
    end else if (tckFall) begin
      tdoOe_n <= ~((state_q == ST_SHF_DR) | (state_q == ST_SHF_IR));
      if (state_q == ST_SHF_IR) begin
        tdo <= irShift_q[0];
      end else if (selBsr) begin
        tdo <= bsrShift_q[0];
      end else if (selId) begin
        tdo <= idShift_q[0];
      end else begin
        tdo <= bypass_q;
      end
    end
  end

  assign cellOut = bsrUpd_q[107:0];
  assign extestDrive = (irCur_q == `BST_OP_EXTEST);
  assign outBusEnable = (irCur_q == `BST_OP_SAMPLEZ) ? 1'b0 :
                        extestDrive ? bsrUpd_q[`BST_OE_CELL] : 1'b1;

  // AXI4-Lite slave: ctrl bit0 is a spare read/write bit
  reg [31:0] ctrl_q;
  reg awHeld_q, wHeld_q;
  reg [31:0] awAddr_q, wData_q;
  reg [3:0] wStrb_q;
  assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire [31:0] awA = awHeld_q ? awAddr_q : s_axi_awaddr;
  wire [31:0] wD = wHeld_q ? wData_q : s_axi_wdata;
  wire [3:0] wS = wHeld_q ? wStrb_q : s_axi_wstrb;
  wire awHave = awHeld_q | (s_axi_awvalid & s_axi_awready);
  wire wHave = wHeld_q | (s_axi_wvalid & s_axi_wready);
  wire doWrite = awHave & wHave & ~s_axi_bvalid;

  function [31:0] strbMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      strbMerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) strbMerge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // word compare; the two low address bits are ignored, writes merge only the bytes whose strobe is set
  function regIs;
    input [31:0] addr;
    input [31:0] off;
    begin
      regIs = (addr[31:2] == off[31:2]);
    end
  endfunction

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_q <= `BST_CTRL_RESET;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 32'h00000000;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BST_AXI_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `BST_AXI_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (regIs(awA, `BST_OFF_CTRL)) begin
          ctrl_q <= strbMerge(ctrl_q, wD, wS) & 32'h00000001;
          s_axi_bresp <= `BST_AXI_OKAY;
        end else if (regIs(awA, `BST_OFF_STATUS) |
                     regIs(awA, `BST_OFF_IDCODE)) begin
          s_axi_bresp <= `BST_AXI_OKAY;
        end else begin
          s_axi_bresp <= `BST_AXI_SLVERR;
        end
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          awHeld_q <= 1'b1;
          awAddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          wHeld_q <= 1'b1;
          wData_q <= s_axi_wdata;
          wStrb_q <= s_axi_wstrb;
        end
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `BST_AXI_OKAY;
        if (regIs(s_axi_araddr, `BST_OFF_CTRL)) begin
          s_axi_rdata <= ctrl_q;
        end else if (regIs(s_axi_araddr, `BST_OFF_STATUS)) begin
          s_axi_rdata <= {19'h0, outBusEnable, irCur_q, state_q, 1'b0, tmsCount_q, tdoOe_n};
        end else if (regIs(s_axi_araddr, `BST_OFF_IDCODE)) begin
          s_axi_rdata <= ID_CODE;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `BST_AXI_SLVERR;
        end
      end
    end
  end
endmodule

// ---- sim/bst_tap_chk.sv ----
module bst_tap_chk (
  input wire sys_clk,
  input wire reset_n,
  input wire tck,
  input wire tms,
  input wire tdo,
  input wire tdoOe_n,
  input wire extestDrive,
  input wire outBusEnable,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // tck rises seen with tms high, saturating
  reg [2:0] tmsRun_q;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) tmsRun_q <= 3'h0;
    else if ($rose(tck))
      tmsRun_q <= !tms ? 3'h0 : (tmsRun_q == 3'h5) ? tmsRun_q : tmsRun_q + 3'h1;
  end
  a_reset_vals: assert property (
    $rose(reset_n) |-> tdoOe_n && outBusEnable && !extestDrive) else $error("bad reset values");
  a_tms_reset: assert property (
    $rose(tck) && tms && tmsRun_q == 3'h4 |-> ##[1:8] (tdoOe_n && outBusEnable && !extestDrive))
    else $error("tms reset ignored");
  a_tdo_fall: assert property (
    tck && $past(tck) && $past(tck, 2) |-> $stable(tdo) && $stable(tdoOe_n))
    else $error("tdo moved while tck high");
  a_tap_quiet: assert property (
    $stable(tck) [*8] |-> $stable(tdo) && $stable(outBusEnable) && $stable(extestDrive))
    else $error("tap moved without tck");
  a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("no write answer");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after handshake");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held after handshake");
endmodule

// ---- sim/bst_jtag_ctl.sv ----
module bst_jtag_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // tck stands low between frames; tdo read just before the rise
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #16 o = tdo;
    tck = 1'b1;
    #16 tck = 1'b0;
  endtask
  // tdi rests at its pull-up level outside shifts
  task automatic walk(input logic [7:0] s, input int n);
    logic o;
    for (int i = 0; i < n; i++) tick(s[i], 1'b1, o);
  endtask
  task automatic scan(input logic ir, input int n, input logic [108:0] din,
      output logic [108:0] dout);
    logic o;
    dout = '0;
    #1 walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    walk(8'h01, 2);
  endtask
endmodule

// ---- sim/tb_top.sv ----
`include "bst_tap_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // arbitrary identification value
  localparam logic [31:0] ID = 32'h5A5A0F01;
  logic sys_clk, reset_n, tck, tms, tdi, tdo, tdoOe_n, extestDrive, outBusEnable;
  logic [107:0] pinRing, cellOut;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [108:0] got, pat;
  int errTotal, numChecks;
  bst_tap #(.ID_CODE(ID)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOe_n(tdoOe_n), .pinRing(pinRing), .cellOut(cellOut), .extestDrive(extestDrive),
    .outBusEnable(outBusEnable), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  bst_jtag_ctl u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic testDone;
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [108:0] s, input logic [108:0] e);
    numChecks++;
    if (s !== e) begin
      errTotal++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic axi(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    for (int i = 0; i < 64; i++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!(s_axi_bvalid || s_axi_rvalid)) begin
      errTotal++;
      testDone;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    pinRing = {3{36'h9A5C3E71B}};
    pat = {1'b0, {4{27'h5A3C0F1}}};
    errTotal = 0;
    numChecks = 0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    u_ctl.walk(8'h00, 1);
    u_ctl.scan(1'b0, 32, '0, got);
    chk("idcode", got[31:0], ID);
    u_ctl.scan(1'b1, 3, `BST_OP_BYPASS, got);
    chk("ircap", got[1:0], 2'h1);
    u_ctl.scan(1'b0, 4, 4'hB, got);
    chk("bypass", got[3:0], 4'h6);
    u_ctl.scan(1'b1, 3, `BST_OP_SAMPLE, got);
    u_ctl.scan(1'b0, 109, pat, got);
    chk("sample", got, {1'b1, pinRing});
    chk("preload", cellOut, pat[107:0]);
    u_ctl.scan(1'b1, 3, `BST_OP_EXTEST, got);
    chk("extest", {extestDrive, outBusEnable}, 2'h2);
    u_ctl.scan(1'b0, 109, ~pat, got);
    chk("extcap", got, {1'b0, pinRing});
    chk("extout", {outBusEnable, cellOut}, ~pat);
    u_ctl.scan(1'b0, 109, pat, got);
    u_ctl.walk(8'h1F, 6);
    u_ctl.scan(1'b0, 32, '0, got);
    chk("tapreset", got[31:0], ID);
    u_ctl.scan(1'b1, 3, `BST_OP_EXTEST, got);
    chk("preset", outBusEnable, 1'b1);
    u_ctl.scan(1'b1, 3, `BST_OP_SAMPLEZ, got);
    chk("hiz", {extestDrive, outBusEnable}, 2'h0);
    axi(1'b0, `BST_OFF_IDCODE, 32'h0);
    chk("regid", {r, q}, {`BST_AXI_OKAY, ID});
    axi(1'b1, `BST_OFF_CTRL, 32'h1);
    chk("wresp", r, `BST_AXI_OKAY);
    axi(1'b0, `BST_OFF_CTRL, 32'h0);
    chk("ctrl", q, 32'h1);
    axi(1'b0, 32'h0000000C, 32'h0);
    chk("unmapped", {r, q}, {`BST_AXI_SLVERR, 32'h0});
    axi(1'b0, `BST_OFF_STATUS, 32'h0);
    chk("status", q[11:9], `BST_OP_SAMPLEZ);
    chk("oeidle", tdoOe_n, 1'b1);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    axi(1'b0, `BST_OFF_STATUS, 32'h0);
    chk("rstinstr", q[12:9], {1'b1, `BST_OP_IDCODE});
    testDone;
  end
endmodule
bind bst_tap bst_tap_chk u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdo(tdo), .tdoOe_n(tdoOe_n),
  .extestDrive(extestDrive), .outBusEnable(outBusEnable),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
